// ===== cifa_pkg.sv
package cifa_pkg;

  // Pulse timing
  localparam int unsigned PULSE_TIME_MS = 2;
  localparam int unsigned CLK_FREQ_KHZ = 40000;
  localparam int unsigned PULSE_CYC = PULSE_TIME_MS * CLK_FREQ_KHZ;

  // Bus and register geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned WORD_SHIFT = 2;
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_STICKY1 = 8'h2a;
  localparam logic [7:0] IDX_STICKY2 = 8'h2c;
  localparam logic [7:0] IDX_STICKY3 = 8'h2d;
  localparam logic [7:0] IDX_LIVE2 = 8'h2e;
  localparam logic [7:0] IDX_LIVE3 = 8'h2f;
  localparam logic [7:0] IDX_CTRL = 8'h30;

  // Flag register two layout (sticky and live)
  localparam int unsigned B_OCP_L = 7;
  localparam int unsigned B_OCP_R = 6;
  localparam int unsigned B_DRC_L = 3;
  localparam int unsigned B_DRC_R = 2;
  localparam int unsigned B_PLAY_STD = 1;
  localparam int unsigned B_PLAY_AUX = 0;

  // Flag register three layout (sticky and live)
  localparam int unsigned B_NOISE_L = 6;
  localparam int unsigned B_NOISE_R = 5;
  localparam int unsigned B_REC_STD = 4;
  localparam int unsigned B_REC_AUX = 3;
  localparam int unsigned B_DCM_L = 2;
  localparam int unsigned B_DCM_R = 1;
  localparam logic [7:0] S3_USED = 8'h7e;

  // Sticky register one layout
  localparam int unsigned B_BSH_PLAY = 5;
  localparam int unsigned B_BSH_REC = 1;

  // Primary interrupt control layout
  localparam int unsigned C_EN_DRC = 5;
  localparam int unsigned C_EN_NOISE = 4;
  localparam int unsigned C_EN_OCP = 3;
  localparam int unsigned C_EN_DSP = 2;
  localparam int unsigned C_EN_DCM = 1;
  localparam int unsigned C_TRAIN = 0;

  typedef struct packed {
    logic ocp_l;
    logic ocp_r;
    logic drc_l;
    logic drc_r;
    logic noise_l;
    logic noise_r;
    logic rec_std;
    logic rec_aux;
    logic play_std;
    logic play_aux;
    logic dcm_l;
    logic dcm_r;
    logic bsh_rec_ovf;
    logic bsh_play_ovf;
  } cifa_evt_s;

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} cifa_pulse_e;

endpackage

// ===== cifa_top.sv
// Behaviour
// RQ1 - Sticky three bits 6,5 latch left/right noise condition, clear on read.
// RQ2 - Sticky three bits 4,3 latch record core standard/auxiliary interrupt ports.
// RQ3 - Sticky three bits 2,1 latch DC measurement ready, clear on read.
// RQ4 - Sticky three bits 7 and 0 are reserved and read zero.
// RQ5 - Live two bits 7,6 show present headphone over-current, not latched.
// RQ6 - Live two bits 3,2 show present dynamic-range threshold exceedance.
// RQ7 - Live two bits 1,0 show playback core interrupt ports at read time.
// RQ8 - Live three bits 6,5 show present noise condition; read does not clear.
// RQ9 - Live three bits 4,3 show record core interrupt ports at read time.
// RQ10 - Live three bits 2,1 show DC measurement data currently available.
// RQ11 - Control bit 5 lets dynamic-range exceedance raise the primary interrupt.
// RQ12 - Control bit 4 lets the noise condition raise the primary interrupt.
// RQ13 - Control bit 3 lets headphone over-current raise the primary interrupt.
// RQ14 - Control bit 2 lets either core's interrupt raise the primary interrupt.
// RQ15 - Control bit 1 lets DC measurement ready raise the primary interrupt.
// RQ16 - Control bit 0 low: each event gives one 2 ms high pulse.
// RQ17 - Control bit 0 high: repeating 2 ms pulses until a sticky read.
// RQ18 - Software keeps control bits 7,6 at zero.
// RQ19 - Sticky two bits 7,6 latch headphone over-current, clear on read.
// RQ20 - Sticky two bits 3,2 latch dynamic-range exceedance, clear on read.
// RQ21 - Sticky one bits 5,1 latch barrel-shifter overflow, clear on read.
// RQ22 - Request is OR of enabled groups; pulse starts on its rising edge.
// RQ23 - Pulse length is a cycle count set by a parameter.
//
// Implementation choice: register access over AHB-Lite.
module cifa_top #(
  parameter int unsigned PULSE_CYCLES = cifa_pkg::PULSE_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire cifa_pkg::cifa_evt_s EVT_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic PRIMARY_IRQ_OUT_O
);

  localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);

  function automatic logic [31:0] reg_addr(input logic [7:0] idx);
    reg_addr = 32'(idx) << cifa_pkg::WORD_SHIFT;
  endfunction

  // Hardware set wins over a clear in the same cycle
  function automatic logic [7:0] sticky_next(input logic [7:0] q,
                                            input logic [7:0] set,
                                            input logic clr);
    sticky_next = (q & ~{8{clr}}) | set;
  endfunction

  logic [7:0] sticky1_q;
  logic [7:0] sticky2_q;
  logic [7:0] sticky3_q;
  logic [7:0] ctrl_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic hresp_q;
  logic wr_pend_q;
  logic wr_ctrl_q;
  logic irq_q;
  logic req_q;
  logic run_q;
  logic run_d;
  logic [CNT_W-1:0] cnt_q;
  cifa_pkg::cifa_pulse_e st_q;
  cifa_pkg::cifa_pulse_e st_d;
  logic [7:0] live2;
  logic [7:0] live3;
  logic [7:0] set1;
  logic [7:0] rd_val;
  logic [7:0] ctrl_view;

  // Live flag vectors; unlisted bits stay zero
  always_comb
  begin
    live2 = cifa_pkg::REG_RST;
    live2[cifa_pkg::B_OCP_L] = EVT_I.ocp_l; // RQ5
    live2[cifa_pkg::B_OCP_R] = EVT_I.ocp_r; // RQ5
    live2[cifa_pkg::B_DRC_L] = EVT_I.drc_l; // RQ6
    live2[cifa_pkg::B_DRC_R] = EVT_I.drc_r; // RQ6
    live2[cifa_pkg::B_PLAY_STD] = EVT_I.play_std; // RQ7
    live2[cifa_pkg::B_PLAY_AUX] = EVT_I.play_aux; // RQ7
  end

  always_comb
  begin
    live3 = cifa_pkg::REG_RST;
    live3[cifa_pkg::B_NOISE_L] = EVT_I.noise_l; // RQ8
    live3[cifa_pkg::B_NOISE_R] = EVT_I.noise_r; // RQ8
    live3[cifa_pkg::B_REC_STD] = EVT_I.rec_std; // RQ9
    live3[cifa_pkg::B_REC_AUX] = EVT_I.rec_aux; // RQ9
    live3[cifa_pkg::B_DCM_L] = EVT_I.dcm_l; // RQ10
    live3[cifa_pkg::B_DCM_R] = EVT_I.dcm_r; // RQ10
  end

  always_comb
  begin
    set1 = cifa_pkg::REG_RST;
    set1[cifa_pkg::B_BSH_PLAY] = EVT_I.bsh_play_ovf; // RQ21
    set1[cifa_pkg::B_BSH_REC] = EVT_I.bsh_rec_ovf; // RQ21
  end

  // Bus decode
  wire ap_ok = CE_I && HSEL_I && HREADY_I
               && HTRANS_I[cifa_pkg::HTRANS_ACT_BIT];
  wire rd_ap = ap_ok && !HWRITE_I;
  wire wr_ap = ap_ok && HWRITE_I;
  wire hit_s1 = HADDR_I == reg_addr(cifa_pkg::IDX_STICKY1);
  wire hit_s2 = HADDR_I == reg_addr(cifa_pkg::IDX_STICKY2);
  wire hit_s3 = HADDR_I == reg_addr(cifa_pkg::IDX_STICKY3);
  wire hit_l2 = HADDR_I == reg_addr(cifa_pkg::IDX_LIVE2);
  wire hit_l3 = HADDR_I == reg_addr(cifa_pkg::IDX_LIVE3);
  wire hit_ct = HADDR_I == reg_addr(cifa_pkg::IDX_CTRL);
  wire clr1 = rd_ap && hit_s1; // RQ21
  wire clr2 = rd_ap && hit_s2; // RQ19 RQ20
  wire clr3 = rd_ap && hit_s3; // RQ1 RQ3
  wire ctrl_wr = CE_I && wr_pend_q && wr_ctrl_q;

  // A read right behind a control write sees the new value
  assign ctrl_view = (wr_pend_q && wr_ctrl_q) ?
                     HWDATA_I[cifa_pkg::REG_W-1:0] : ctrl_q;

  assign rd_val = hit_s1 ? sticky1_q :
                  hit_s2 ? sticky2_q :
                  hit_s3 ? sticky3_q :
                  hit_l2 ? live2 :
                  hit_l3 ? live3 :
                  hit_ct ? ctrl_view : cifa_pkg::REG_RST;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      hrdata_q <= cifa_pkg::RDATA_RST;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ctrl_q <= 1'b0;
      ctrl_q <= cifa_pkg::REG_RST;
    end
    else if (CE_I)
    begin
      hrdata_q <= rd_ap ? 32'(rd_val) : cifa_pkg::RDATA_RST;
      if (HREADY_I)
      begin
        wr_pend_q <= wr_ap;
        wr_ctrl_q <= hit_ct;
      end
      if (ctrl_wr)
        ctrl_q <= HWDATA_I[cifa_pkg::REG_W-1:0]; // RQ18
    end
  end

  // Sticky flags
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      sticky1_q <= cifa_pkg::REG_RST;
      sticky2_q <= cifa_pkg::REG_RST;
      sticky3_q <= cifa_pkg::REG_RST; // RQ4
    end
    else if (CE_I)
    begin
      sticky1_q <= sticky_next(sticky1_q, set1, clr1); // RQ21
      sticky2_q <= sticky_next(sticky2_q, live2, clr2); // RQ19 RQ20
      sticky3_q <= sticky_next(sticky3_q, live3, clr3); // RQ1 RQ2 RQ3
    end
  end

  // Interrupt request from enabled groups
  wire grp_drc = EVT_I.drc_l || EVT_I.drc_r;
  wire grp_noise = EVT_I.noise_l || EVT_I.noise_r;
  wire grp_ocp = EVT_I.ocp_l || EVT_I.ocp_r;
  wire grp_dsp = EVT_I.rec_std || EVT_I.rec_aux
                 || EVT_I.play_std || EVT_I.play_aux;
  wire grp_dcm = EVT_I.dcm_l || EVT_I.dcm_r;
  wire req = (ctrl_q[cifa_pkg::C_EN_DRC] && grp_drc) // RQ11
          || (ctrl_q[cifa_pkg::C_EN_NOISE] && grp_noise) // RQ12
          || (ctrl_q[cifa_pkg::C_EN_OCP] && grp_ocp) // RQ13
          || (ctrl_q[cifa_pkg::C_EN_DSP] && grp_dsp) // RQ14
          || (ctrl_q[cifa_pkg::C_EN_DCM] && grp_dcm); // RQ15 RQ22
  wire req_rise = req && !req_q; // RQ22
  wire train = ctrl_q[cifa_pkg::C_TRAIN];
  wire stop = clr1 || clr2 || clr3; // RQ17
  wire cnt_end = cnt_q == CNT_W'(PULSE_CYCLES - 1); // RQ23
  wire start = (st_q == cifa_pkg::ST_IDLE) && req_rise;

  // Train keeps running until software reads a sticky register
  assign run_d = train && ((start && train) || (run_q && !stop)); // RQ17

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      cifa_pkg::ST_IDLE:
        if (req_rise)
          st_d = cifa_pkg::ST_HIGH; // RQ22
      cifa_pkg::ST_HIGH:
        if (cnt_end)
          st_d = run_d ? cifa_pkg::ST_LOW : cifa_pkg::ST_IDLE; // RQ16
      cifa_pkg::ST_LOW:
        if (!run_d)
          st_d = cifa_pkg::ST_IDLE;
        else if (cnt_end)
          st_d = cifa_pkg::ST_HIGH; // RQ17
      default:
        st_d = cifa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      st_q <= cifa_pkg::ST_IDLE;
      cnt_q <= '0;
      req_q <= 1'b0;
      run_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (CE_I)
    begin
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? '0 : cnt_q + 1'b1; // RQ23
      req_q <= req;
      run_q <= run_d;
      irq_q <= st_d == cifa_pkg::ST_HIGH; // RQ16 RQ17
    end
  end

  assign HRDATA_O = hrdata_q;
  assign HREADYOUT_O = hready_q;
  assign HRESP_O = hresp_q;
  assign PRIMARY_IRQ_OUT_O = irq_q;

  // Checks
  int unsigned hi_cnt_q;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I || !irq_q)
      hi_cnt_q <= 0;
    else if (CE_I)
      hi_cnt_q <= hi_cnt_q + 1;
  end

  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (RST_I);

  chk_noise_sticky: assert property ( // RQ1
    CE_I && EVT_I.noise_l |=> sticky3_q[cifa_pkg::B_NOISE_L])
    else $error("noise event not latched");

  chk_core_hold: assert property ( // RQ2
    CE_I && sticky3_q[cifa_pkg::B_REC_STD] && !clr3
    |=> sticky3_q[cifa_pkg::B_REC_STD])
    else $error("record core sticky bit lost");

  chk_sticky_clear: assert property ( // RQ3
    CE_I && clr3 && live3 == cifa_pkg::REG_RST
    |=> sticky3_q == cifa_pkg::REG_RST)
    else $error("sticky three not cleared by read");

  chk_rsvd_zero: assert property ( // RQ4
    (sticky3_q & ~cifa_pkg::S3_USED) == cifa_pkg::REG_RST)
    else $error("reserved sticky bit set");

  chk_live2_read: assert property ( // RQ5 RQ6 RQ7
    rd_ap && hit_l2
    |=> HRDATA_O[cifa_pkg::REG_W-1:0] == $past(live2))
    else $error("live two read mismatch");

  chk_live3_read: assert property ( // RQ8 RQ9 RQ10
    rd_ap && hit_l3
    |=> HRDATA_O[cifa_pkg::REG_W-1:0] == $past(live3))
    else $error("live three read mismatch");

  chk_ocp_sticky: assert property ( // RQ19
    CE_I && EVT_I.ocp_r |=> sticky2_q[cifa_pkg::B_OCP_R])
    else $error("over-current not latched");

  chk_drc_sticky: assert property ( // RQ20
    CE_I && EVT_I.drc_l |=> sticky2_q[cifa_pkg::B_DRC_L])
    else $error("threshold event not latched");

  chk_bsh_sticky: assert property ( // RQ21
    CE_I && EVT_I.bsh_rec_ovf |=> sticky1_q[cifa_pkg::B_BSH_REC])
    else $error("overflow not latched");

  chk_mask_quiet: assert property ( // RQ11 RQ12 RQ13 RQ14 RQ15
    CE_I && st_q == cifa_pkg::ST_IDLE && !req |=> !PRIMARY_IRQ_OUT_O)
    else $error("interrupt without enabled request");

  chk_pulse_start: assert property ( // RQ22
    start && CE_I |=> PRIMARY_IRQ_OUT_O)
    else $error("pulse did not start on request edge");

  chk_pulse_len: assert property ( // RQ16 RQ23
    $fell(PRIMARY_IRQ_OUT_O) |-> hi_cnt_q == PULSE_CYCLES)
    else $error("pulse length wrong");

  chk_single_once: assert property ( // RQ16
    CE_I && st_q == cifa_pkg::ST_HIGH && cnt_end && !train
    |=> st_q == cifa_pkg::ST_IDLE)
    else $error("single pulse mode repeated");

  chk_train_repeat: assert property ( // RQ17
    CE_I && st_q == cifa_pkg::ST_LOW && cnt_end && run_q && train && !stop
    |=> PRIMARY_IRQ_OUT_O)
    else $error("pulse train did not repeat");

  chk_bus_okay: assert property (
    HREADYOUT_O && !HRESP_O)
    else $error("bus answer not ready and okay");

  chk_core_latch: assert property ( // RQ2
    CE_I && EVT_I.rec_aux |=> sticky3_q[cifa_pkg::B_REC_AUX])
    else $error("record core auxiliary port not latched");

  chk_dcm_right: assert property ( // RQ3
    CE_I && EVT_I.dcm_r |=> sticky3_q[cifa_pkg::B_DCM_R])
    else $error("right measurement flag not latched");

  chk_noise_right: assert property ( // RQ1
    CE_I && EVT_I.noise_r |=> sticky3_q[cifa_pkg::B_NOISE_R])
    else $error("right noise event not latched");

  chk_ocp_left: assert property ( // RQ19
    CE_I && EVT_I.ocp_l |=> sticky2_q[cifa_pkg::B_OCP_L])
    else $error("left over-current not latched");

  chk_drc_right: assert property ( // RQ20
    CE_I && EVT_I.drc_r |=> sticky2_q[cifa_pkg::B_DRC_R])
    else $error("right threshold event not latched");

  chk_bsh_play: assert property ( // RQ21
    CE_I && EVT_I.bsh_play_ovf |=> sticky1_q[cifa_pkg::B_BSH_PLAY])
    else $error("playback overflow not latched");

  chk_sticky2_clear: assert property ( // RQ19 RQ20
    CE_I && clr2 && live2 == cifa_pkg::REG_RST
    |=> sticky2_q == cifa_pkg::REG_RST)
    else $error("sticky two not cleared by read");

  chk_sticky1_clear: assert property ( // RQ21
    CE_I && clr1 && set1 == cifa_pkg::REG_RST
    |=> sticky1_q == cifa_pkg::REG_RST)
    else $error("sticky one not cleared by read");

  chk_no_retrigger: assert property ( // RQ22
    CE_I && st_q == cifa_pkg::ST_IDLE && !req_rise
    |=> !PRIMARY_IRQ_OUT_O)
    else $error("pulse started without request edge");

  chk_train_stop: assert property ( // RQ17
    CE_I && st_q == cifa_pkg::ST_LOW && stop
    |=> st_q == cifa_pkg::ST_IDLE)
    else $error("pulse train not stopped by sticky read");

  chk_train_gap: assert property ( // RQ17
    CE_I && st_q == cifa_pkg::ST_HIGH && cnt_end && train && run_q && !stop
    |=> !PRIMARY_IRQ_OUT_O && st_q == cifa_pkg::ST_LOW)
    else $error("pulse train gap missing");

  chk_read_idle: assert property (
    CE_I && !rd_ap |=> HRDATA_O == cifa_pkg::RDATA_RST)
    else $error("read data outside read data phase");

  chk_ctrl_write: assert property ( // RQ11 RQ16
    ctrl_wr
    |=> ctrl_q == $past(HWDATA_I[cifa_pkg::REG_W-1:0]))
    else $error("control write not stored");

  chk_ce_freeze: assert property (
    !CE_I
    |=> $stable(st_q) && $stable(cnt_q) && $stable(sticky3_q))
    else $error("state moved while clock enable low");

endmodule

// ===== cifa_host_mon.sv
module cifa_host_mon (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  output int rise_o,
  output int width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int run_q;
  logic irq_q;
  // Host interrupt input: counts pulses and the length of the last one
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rise_o <= 0;
      width_o <= 0;
      run_q <= 0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_i;
      run_q <= irq_i ? run_q + 1 : 0;
      if (irq_i && !irq_q)
        rise_o <= rise_o + 1;
      if (!irq_i && irq_q)
        width_o <= run_q;
    end
  end
endmodule

// ===== codec_irq_flag_aggregator_test.sv
module codec_irq_flag_aggregator_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  cifa_pkg::cifa_evt_s evt = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  int rise;
  int width;
  int err_total = 0;
  int samples_checked = 0;
  int r0;
  logic [31:0] rd;
  logic [7:0] idx [6] = '{8'h2a, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30};
  logic [13:0] gev [5] = '{14'h0800, 14'h0200, 14'h1000, 14'h0080, 14'h0008};
  always #12.5 clk = ~clk;
  cifa_top #(.PULSE_CYCLES(P)) i_dut (
    .CLK_I(clk),
    .RST_I(rst),
    .CE_I(ce),
    .HSEL_I(hsel),
    .HADDR_I(haddr),
    .HTRANS_I(htrans),
    .HWRITE_I(hwrite),
    .HSIZE_I(3'h2),
    .HWDATA_I(hwdata),
    .HREADY_I(hready),
    .EVT_I(evt),
    .HRDATA_O(hrdata),
    .HREADYOUT_O(hready),
    .HRESP_O(hresp),
    .PRIMARY_IRQ_OUT_O(irq)
  );
  cifa_host_mon i_host (
    .clk_i(clk),
    .rst_i(rst),
    .irq_i(irq),
    .rise_o(rise),
    .width_o(width)
  );
  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask
  function automatic logic [31:0] ra(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction
  // Single AHB transfer; read data is taken at the data-phase edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    check(rd, {24'h0, e});
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic pul(input logic [13:0] m);
    evt <= cifa_pkg::cifa_evt_s'(m);
    @(posedge clk);
    evt <= '0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    foreach (idx[i])
      rdc(ra(idx[i]), 8'h00);
    rdc(32'h100, 8'h00);
    bus(ra(cifa_pkg::IDX_LIVE2), 1'b1, 8'hff);
    rdc(ra(cifa_pkg::IDX_LIVE2), 8'h00);
    pul(14'h03cc);
    rdc(ra(cifa_pkg::IDX_STICKY3), 8'h7e);
    rdc(ra(cifa_pkg::IDX_STICKY3), 8'h00);
    evt <= cifa_pkg::cifa_evt_s'(14'h2568);
    cyc(2);
    rdc(ra(cifa_pkg::IDX_LIVE2), 8'h86);
    rdc(ra(cifa_pkg::IDX_LIVE3), 8'h2c);
    rdc(ra(cifa_pkg::IDX_LIVE3), 8'h2c);
    pul(14'h0003);
    rdc(ra(cifa_pkg::IDX_LIVE2), 8'h00);
    rdc(ra(cifa_pkg::IDX_STICKY2), 8'h86);
    rdc(ra(cifa_pkg::IDX_STICKY2), 8'h00);
    rdc(ra(cifa_pkg::IDX_STICKY1), 8'h22);
    rdc(ra(cifa_pkg::IDX_STICKY1), 8'h00);
    rdc(ra(cifa_pkg::IDX_STICKY3), 8'h2c);
    // Each group masked by its own bit, then enabled alone
    for (int i = 0; i < 5; i++)
    begin
      bus(ra(cifa_pkg::IDX_CTRL), 1'b1, 8'h3e & ~(8'h20 >> i));
      r0 = rise;
      pul(gev[i]);
      cyc(3 * P);
      check(rise - r0, 0);
      bus(ra(cifa_pkg::IDX_CTRL), 1'b1, 8'h20 >> i);
      rdc(ra(cifa_pkg::IDX_CTRL), 8'h20 >> i);
      r0 = rise;
      pul(gev[i]);
      cyc(3 * P);
      check(rise - r0, 1);
      check(width, P);
    end
    rdc(ra(cifa_pkg::IDX_STICKY3), 8'h54);
    bus(ra(cifa_pkg::IDX_CTRL), 1'b1, 8'h03);
    r0 = rise;
    pul(14'h0008);
    cyc(5 * P);
    check(rise - r0, 3);
    check(width, P);
    rdc(ra(cifa_pkg::IDX_STICKY3), 8'h04);
    r0 = rise;
    cyc(4 * P);
    check(rise - r0, 0);
    // Clock enable low stretches the pulse by the frozen cycles
    bus(ra(cifa_pkg::IDX_CTRL), 1'b1, 8'h02);
    r0 = rise;
    pul(14'h0004);
    cyc(2);
    ce <= 1'b0;
    cyc(4);
    ce <= 1'b1;
    cyc(3 * P);
    check(rise - r0, 1);
    check(width, P + 4);
    print_verdict();
  end
endmodule
